// [src/vmon_pkg.sv]
/*
 * Package for the two-channel voltage monitor event logic: register map,
 * field codes, reset values and timing constants.
 * Assumes a single 40 MHz core clock and a plain strobe register port.
 */
package vmon_pkg;
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned RELEASE_WAIT_US = 100;
	localparam int unsigned RELEASE_CYCLES  = (RELEASE_WAIT_US * (CLK_HZ / 1_000_000));

	// register byte offsets
	localparam logic [7:0] OFS_CH1_CFG   = 8'h00;
	localparam logic [7:0] OFS_CH2_CFG   = 8'h04;
	localparam logic [7:0] OFS_CH1_LVL   = 8'h08;
	localparam logic [7:0] OFS_CH2_LVL   = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_CLEAR     = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h18;
	localparam logic [7:0] OFS_LEVEL_RO  = 8'h1C;

	// detection action codes
	localparam logic [1:0] ACT_RESET = 2'h0;
	localparam logic [1:0] ACT_NMI   = 2'h1;
	localparam logic [1:0] ACT_IRQ   = 2'h2;
	localparam logic [1:0] ACT_NONE  = 2'h3;

	// crossing direction codes
	localparam logic [1:0] DIR_RISE = 2'h0;
	localparam logic [1:0] DIR_FALL = 2'h1;
	localparam logic [1:0] DIR_BOTH = 2'h2;

	localparam logic [7:0] VEC_CH1 = 8'h58;
	localparam logic [7:0] VEC_CH2 = 8'h59;

	localparam logic [3:0] PRIO_RESET   = 4'h3;
	localparam logic [7:0] DIV_RESET    = 8'h01;
	localparam logic [8:0] LEVEL_RESET  = 9'h12C;

	typedef struct packed {
		logic       used;
		logic       source_sel;
		logic       filt_en;
		logic [1:0] action;
		logic       release_mode;
		logic [1:0] direction;
		logic [3:0] prio;
		logic [7:0] div;
	} ch_cfg_t;

	localparam ch_cfg_t CFG_RESET = '{used: 1'b0, source_sel: 1'b0, filt_en: 1'b0, action: ACT_NMI,
		release_mode: 1'b0, direction: DIR_FALL, prio: PRIO_RESET, div: DIV_RESET};

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] vector;
		logic [3:0] prio;
	} irq_req_t;

	typedef enum logic [1:0] {
		RST_IDLE  = 2'b00,
		RST_HOLD  = 2'b01,
		RST_WAIT  = 2'b11
	} rst_state_t;
endpackage : vmon_pkg

// [src/voltage_monitor_event_logic.sv]
/*
 * Two-channel voltage monitor event logic: source select, digital filter,
 * crossing detection, sticky crossing flags, action dispatch to reset,
 * non-maskable and maskable requests, and reset release timing.
 * Configuration, thresholds, flag clear and interrupt enable sit behind a
 * plain strobe register port with read data one cycle after the strobe.
 * Assumes the comparator outputs and the low-speed oscillator are
 * asynchronous to the core clock and are synchronised here with two flops;
 * the interrupt controller and the reset logic sample the registered outputs
 * on the same core clock.
 */
module voltage_monitor_event_logic (
	input  wire logic              core_clk_in,
	input  wire logic              sys_rst_in,
	input  wire vmon_pkg::reg_req_t reg_req_in,
	output logic [31:0]            reg_rdata_out,
	input  wire logic [1:0]        supply_above_in,
	input  wire logic [1:0]        external_compare_pin_in,
	input  wire logic              low_speed_osc_in,
	output logic [8:0]             ch1_level_out,
	output logic [8:0]             ch2_level_out,
	output vmon_pkg::irq_req_t     monitor_ch1_irq_out,
	output vmon_pkg::irq_req_t     monitor_ch2_irq_out,
	output logic                   nmi_out,
	output logic                   monitor_reset_out,
	output logic                   irq_out
);
	import vmon_pkg::*;

	typedef struct packed {
		ch_cfg_t [1:0]    cfg;
		logic [1:0][8:0]  level;
		logic [1:0]       status;
		logic [1:0]       irq_en;
		logic [1:0]       sup_s1;
		logic [1:0]       sup_s2;
		logic [1:0]       ext_s1;
		logic [1:0]       ext_s2;
		logic             osc1;
		logic             osc2;
		logic             osc_prev;
		logic [1:0][7:0]  div_cnt;
		logic [1:0]       filt;
		logic [1:0]       filt_cand;
		logic [1:0]       above_prev;
		rst_state_t [1:0] rst_st;
		logic [1:0][31:0] wait_cnt;
		logic [31:0]      rdata;
		irq_req_t [1:0]   irq;
		logic             nmi;
		logic             rst;
		logic             irq_line;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// channel in service with the given action code
	function automatic logic acts_as(input ch_cfg_t cfg, input logic [1:0] code);
		acts_as = cfg.used && (cfg.action == code);
	endfunction : acts_as

	// one more cycle of the release wait
	function automatic logic [31:0] wait_step(input logic [31:0] cnt);
		wait_step = cnt + 32'h0000_0001;
	endfunction : wait_step

	// wait runs out once the next count reaches the release time
	function automatic logic wait_done(input logic [31:0] cnt);
		wait_done = wait_step(cnt) >= RELEASE_CYCLES;
	endfunction : wait_done

	// divided oscillator: sample on the last tick of each ratio
	function automatic logic div_hit(input logic [7:0] cnt, input logic [7:0] ratio);
		div_hit = (cnt + 8'h01) >= ratio;
	endfunction : div_hit

	// priority zero is no level; lowest level instead
	function automatic logic [3:0] eff_prio(input logic [3:0] p);
		eff_prio = (p == 4'h0) ? 4'h1 : p;
	endfunction : eff_prio

	// channel state asks for the monitor reset
	function automatic logic holding(input rst_state_t st);
		holding = (st != RST_IDLE);
	endfunction : holding

	function automatic logic [31:0] cfg_word(input ch_cfg_t c);
		cfg_word = 32'(c);
	endfunction : cfg_word

	function automatic logic [31:0] lvl_word(input logic [8:0] l);
		lvl_word = 32'(l);
	endfunction : lvl_word

	function automatic logic crossed(input logic [1:0] dir, input logic prev, input logic cur);
		logic rise;
		logic fall;
		rise = !prev && cur;
		fall = prev && !cur;
		case (dir)
			DIR_RISE: crossed = rise;
			DIR_FALL: crossed = fall;
			DIR_BOTH: crossed = rise || fall;
			default:  crossed = 1'b0;
		endcase
	endfunction : crossed

	always_comb begin
		logic       osc_tick;
		logic [1:0] raw;
		logic [1:0] above;
		logic [1:0] hit;
		logic [1:0] clr;
		s_nxt = s_r;
		hit = '0;
		clr = '0;
		raw = '0;
		above = '0;
		osc_tick = 1'b0;

		// two-flop synchronisers on both comparator sources
		s_nxt.sup_s1 = supply_above_in;
		s_nxt.sup_s2 = s_r.sup_s1;
		s_nxt.ext_s1 = external_compare_pin_in;
		s_nxt.ext_s2 = s_r.ext_s1;

		// rising edge of the synchronised low-speed oscillator
		s_nxt.osc1 = low_speed_osc_in;
		s_nxt.osc2 = s_r.osc1;
		s_nxt.osc_prev = s_r.osc2;
		osc_tick = s_r.osc2 && !s_r.osc_prev;
		for (int i = 0; i < 2; i++) begin
			raw[i] = s_r.cfg[i].source_sel ? s_r.ext_s2[i] : s_r.sup_s2[i];
		end
		above = '0;
		for (int i = 0; i < 2; i++) begin
			// divided oscillator sampling; two equal samples pass the filter
			if (osc_tick) begin
				if (div_hit(s_r.div_cnt[i], s_r.cfg[i].div)) begin
					s_nxt.div_cnt[i] = '0;
					s_nxt.filt_cand[i] = raw[i];
					if (s_r.filt_cand[i] == raw[i]) begin
						s_nxt.filt[i] = raw[i];
					end
				end else begin
					s_nxt.div_cnt[i] = s_r.div_cnt[i] + 8'h01;
				end
			end
			above[i] = s_r.cfg[i].filt_en ? s_r.filt[i] : raw[i];
			s_nxt.above_prev[i] = above[i];
			if (s_r.cfg[i].used) begin
				hit[i] = crossed(s_r.cfg[i].direction, s_r.above_prev[i], above[i]);
			end
		end

		for (int i = 0; i < 2; i++) begin
			// reset sequencing per channel
			case (s_r.rst_st[i])
				RST_IDLE: begin
					if (acts_as(s_r.cfg[i], ACT_RESET) && !above[i]) begin
						s_nxt.rst_st[i] = RST_HOLD;
						s_nxt.wait_cnt[i] = '0;
					end
				end
				RST_HOLD: begin
					s_nxt.wait_cnt[i] = wait_step(s_r.wait_cnt[i]);
					if (s_r.cfg[i].release_mode) begin
						if (wait_done(s_r.wait_cnt[i])) begin
							s_nxt.rst_st[i] = RST_IDLE;
						end
					end else if (above[i]) begin
						s_nxt.rst_st[i] = RST_WAIT;
						s_nxt.wait_cnt[i] = '0;
					end
				end
				RST_WAIT: begin
					s_nxt.wait_cnt[i] = wait_step(s_r.wait_cnt[i]);
					if (!above[i]) begin
						s_nxt.rst_st[i] = RST_HOLD;
						s_nxt.wait_cnt[i] = '0;
					end else if (wait_done(s_r.wait_cnt[i])) begin
						s_nxt.rst_st[i] = RST_IDLE;
					end
				end
				default: s_nxt.rst_st[i] = RST_IDLE;
			endcase
		end

		// register writes
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				OFS_CH1_CFG: begin
					s_nxt.cfg[0] = reg_req_in.wdata[$bits(ch_cfg_t)-1:0];
				end
				OFS_CH2_CFG: begin
					s_nxt.cfg[1] = reg_req_in.wdata[$bits(ch_cfg_t)-1:0];
				end
				OFS_CH1_LVL: begin
					s_nxt.level[0] = reg_req_in.wdata[8:0];
				end
				OFS_CH2_LVL: begin
					s_nxt.level[1] = reg_req_in.wdata[8:0];
				end
				OFS_CLEAR: begin
					clr = reg_req_in.wdata[1:0];
				end
				OFS_IRQ_EN: begin
					s_nxt.irq_en = reg_req_in.wdata[1:0];
				end
				default: ;
			endcase
		end

		// sticky flags: set wins over clear
		s_nxt.status = (s_r.status & ~clr) | hit;
		s_nxt.nmi = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (acts_as(s_r.cfg[i], ACT_NMI) && hit[i]) begin
				s_nxt.nmi = 1'b1;
			end
			s_nxt.irq[i].valid = acts_as(s_r.cfg[i], ACT_IRQ) && hit[i];
			s_nxt.irq[i].prio = eff_prio(s_r.cfg[i].prio);
		end
		s_nxt.irq[0].vector = VEC_CH1;
		s_nxt.irq[1].vector = VEC_CH2;
		s_nxt.rst = holding(s_nxt.rst_st[0]) || holding(s_nxt.rst_st[1]);
		// level request while an enabled flag stands
		s_nxt.irq_line = |(s_nxt.status & s_nxt.irq_en);

		// register reads, data valid one cycle later
		s_nxt.rdata = '0;
		if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				OFS_CH1_CFG: begin
					s_nxt.rdata = cfg_word(s_r.cfg[0]);
				end
				OFS_CH2_CFG: begin
					s_nxt.rdata = cfg_word(s_r.cfg[1]);
				end
				OFS_CH1_LVL: begin
					s_nxt.rdata = lvl_word(s_r.level[0]);
				end
				OFS_CH2_LVL: begin
					s_nxt.rdata = lvl_word(s_r.level[1]);
				end
				OFS_STATUS: begin
					s_nxt.rdata = 32'(s_r.status);
				end
				OFS_IRQ_EN: begin
					s_nxt.rdata = 32'(s_r.irq_en);
				end
				OFS_LEVEL_RO: begin
					s_nxt.rdata = 32'({holding(s_r.rst_st[1]), holding(s_r.rst_st[0]), above});
				end
				default:      s_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
			s_r.cfg[0] <= CFG_RESET;
			s_r.cfg[1] <= CFG_RESET;
			s_r.level[0] <= LEVEL_RESET;
			s_r.level[1] <= LEVEL_RESET;
			s_r.above_prev <= 2'h3;
			s_r.filt <= 2'h3;
			s_r.filt_cand <= 2'h3;
			// comparator pins idle high; no false crossing after reset
			s_r.sup_s1 <= 2'h3;
			s_r.sup_s2 <= 2'h3;
			s_r.ext_s1 <= 2'h3;
			s_r.ext_s2 <= 2'h3;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_out = s_r.rdata;
	assign ch1_level_out = s_r.level[0];
	assign ch2_level_out = s_r.level[1];
	assign monitor_ch1_irq_out = s_r.irq[0];
	assign monitor_ch2_irq_out = s_r.irq[1];
	assign nmi_out = s_r.nmi;
	assign monitor_reset_out = s_r.rst;
	assign irq_out = s_r.irq_line;
endmodule : voltage_monitor_event_logic

// [tb/tb_top.sv]
/* Bench top: random channel setups through the register port and comparators.
   Assumes the checker bound below and the partner model counting requests. */
bind voltage_monitor_event_logic vmon_chk chk_u (.*);
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import vmon_pkg::*;
	logic       core_clk_in = 1'b0, sys_rst_in = 1'b1, low_speed_osc_in = 1'b0;
	logic       nmi_out, monitor_reset_out, irq_out;
	logic [1:0] supply_above_in = 2'b11, external_compare_pin_in = 2'b11;
	logic [8:0] ch1_level_out, ch2_level_out;
	logic [31:0] reg_rdata_out;
	reg_req_t   reg_req_in = '0;
	irq_req_t   monitor_ch1_irq_out, monitor_ch2_irq_out;
	int         req_cnt_out, nmi_cnt_out, n_fail = 0, checked = 0;
	wire        ev = monitor_ch1_irq_out.valid | monitor_ch2_irq_out.valid | nmi_out | monitor_reset_out;
	voltage_monitor_event_logic dut_u (.*);
	vmon_partner host_u (.*);
	initial forever #12.5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) low_speed_osc_in <= low_speed_osc_in ^ ($urandom % 8 == 0);
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic bus(logic [7:0] a, logic [31:0] d, logic w, output logic [31:0] q);
		@(posedge core_clk_in);
		reg_req_in <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge core_clk_in);
		reg_req_in <= '0;
		#1 q = reg_rdata_out;
	endtask : bus
	// w 0 waits for any event, w 1 for the monitor reset to drop
	task automatic wt(int w, int lim, int must, output int n);
		for (n = 0; n < lim && (w ? !monitor_reset_out : ev) !== 1'b1; n++) @(posedge core_clk_in) #1;
		chk("wait", 0, 32'(must && n == lim));
		if (must && n == lim) finish_test();
	endtask : wt
	initial begin
		int ch, a, u, src, n, dir, p, en, c0, c1;
		logic [31:0] q;
		void'($urandom(73));
		repeat (4) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		bus(OFS_CH1_CFG, 0, 0, q);
		chk("cfg_reset", 32'h0000_9301, q);
		chk("level_reset", 32'h0000_012C, 32'(ch1_level_out));
		bus(8'h40, 0, 0, q);
		chk("unmapped", 32'h0000_0000, q);
		bus(OFS_CH1_LVL, 32'h0000_01AD, 1, q);
		bus(OFS_CH2_LVL, 32'h0000_01AD, 1, q);
		chk("ch1_level", 32'h0000_01AD, 32'(ch1_level_out));
		chk("ch2_level", 32'h0000_01AD, 32'(ch2_level_out));
		bus(OFS_CH2_LVL, 0, 0, q);
		chk("level_read", 32'h0000_01AD, q);
		for (int t = 0; t < 16; t++) begin
			ch = t % 2;
			a = (t / 2) % 4;
			u = (t != 4);
			src = $urandom % 2;
			dir = (a == 0) ? $urandom % 3 : 1 + $urandom % 2;
			p = 1 + $urandom % 15;
			en = $urandom % 4;
			bus(OFS_CH1_CFG + 8'(4 * ch), {12'h000, 1'(u), 1'(src), 1'($urandom), 2'(a), 1'(t / 8), 2'(dir),
				4'(p), 8'(1 + $urandom % 4)}, 1, q);
			bus(OFS_IRQ_EN, 32'(en), 1, q);
			c0 = req_cnt_out;
			c1 = nmi_cnt_out;
			if (src) external_compare_pin_in[ch] <= 1'b0;
			else supply_above_in[ch] <= 1'b0;
			wt(0, 600, (a != 3) && u, n);
			if (a == 3 || !u) chk("quiet", 1, n == 600);
			if (a == 0 && t >= 8) begin
				supply_above_in[ch] <= 1'b1;
				external_compare_pin_in[ch] <= 1'b1;
			end
			if (a == 0) begin
				wt(1, 4500, 0, n);
				chk("hold", t / 8, n < 4500);
				if (t >= 8) chk("hold_len", 1, n >= 3990 && n < 4010);
			end
			supply_above_in[ch] <= 1'b1;
			external_compare_pin_in[ch] <= 1'b1;
			wt(1, 4400, 1, n);
			if (a == 0 && t < 8) chk("release", 1, n >= 4000);
			repeat (400) @(posedge core_clk_in);
			chk("irq_count", c0 + (a == 2) * u * (1 + (dir == 2)), req_cnt_out);
			chk("nmi_count", c1 + (a == 1) * u * (1 + (dir == 2)), nmi_cnt_out);
			chk("irq_level", u & en[ch], irq_out);
			bus(OFS_STATUS, 0, 0, q);
			chk("status", u, q[ch]);
			bus(OFS_CLEAR, 32'h0000_0001 << ch, 1, q);
			$display("test %0d done", t);
		end
		finish_test();
	end
endmodule : tb_top

// [tb/vmon_chk.sv]
/* Port checker for the voltage monitor event logic.
   Assumes a bind onto the top module and the single core clock. */
module vmon_chk (
	input wire logic               core_clk_in,
	input wire logic               sys_rst_in,
	input wire vmon_pkg::reg_req_t reg_req_in,
	input wire logic [31:0]        reg_rdata_out,
	input wire logic [8:0]         ch1_level_out,
	input wire vmon_pkg::irq_req_t monitor_ch1_irq_out,
	input wire vmon_pkg::irq_req_t monitor_ch2_irq_out,
	input wire logic               nmi_out,
	input wire logic               monitor_reset_out
);
	import vmon_pkg::*;
	int hold_cnt;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// cycles the monitor reset has been held so far
	always_ff @(posedge core_clk_in)
		hold_cnt <= (sys_rst_in || !monitor_reset_out) ? 0 : hold_cnt + 1;
	sequence s_idle;
		!reg_req_in.rd;
	endsequence
	AST_VEC1: assert property (monitor_ch1_irq_out.valid |->
		monitor_ch1_irq_out.vector == VEC_CH1) else $error("ch1 vector wrong");
	AST_VEC2: assert property (monitor_ch2_irq_out.valid |->
		monitor_ch2_irq_out.vector == VEC_CH2) else $error("ch2 vector wrong");
	AST_PRIO: assert property (monitor_ch1_irq_out.valid |->
		monitor_ch1_irq_out.prio != 4'h0) else $error("ch1 priority zero");
	AST_PULSE: assert property (monitor_ch2_irq_out.valid |=>
		!monitor_ch2_irq_out.valid) else $error("ch2 request too long");
	AST_NMI: assert property ($rose(nmi_out) |=> !nmi_out) else $error("nmi too long");
	AST_RDZ: assert property (s_idle |=> reg_rdata_out == 32'h0000_0000) else $error("read data stray");
	AST_HOLD: assert property ($fell(monitor_reset_out) && !$past(sys_rst_in) |->
		hold_cnt >= RELEASE_CYCLES - 1) else $error("reset released early");
	AST_LVL: assert property ($changed(ch1_level_out) && !$past(sys_rst_in) |->
		$past(reg_req_in.wr) || $past(reg_req_in.wr, 2)) else $error("level changed alone");
endmodule : vmon_chk

// [tb/vmon_partner.sv]
/* Interrupt controller model: takes requests on their vectors, counts them.
   Assumes one-cycle registered request pulses from the monitor. */
module vmon_partner (
	input  wire logic               core_clk_in,
	input  wire logic               sys_rst_in,
	input  wire vmon_pkg::irq_req_t monitor_ch1_irq_out,
	input  wire vmon_pkg::irq_req_t monitor_ch2_irq_out,
	input  wire logic               nmi_out,
	output int                      req_cnt_out,
	output int                      nmi_cnt_out
);
	import vmon_pkg::*;
	always @(posedge core_clk_in) begin
		req_cnt_out <= sys_rst_in ? 0 : req_cnt_out
			+ int'(monitor_ch1_irq_out.valid && monitor_ch1_irq_out.vector == 8'h58)
			+ int'(monitor_ch2_irq_out.valid && monitor_ch2_irq_out.vector == 8'h59);
		nmi_cnt_out <= sys_rst_in ? 0 : nmi_cnt_out + int'(nmi_out);
	end
endmodule : vmon_partner
